//--- include/psc_defs.svh
// Purpose: Constants for the phase shifter control link and its host
// Assumes: Serial word is six bits, phase bits in the upper four
// Notes: Timing constants and register map below
`ifndef PSC_DEFS_SVH
`define PSC_DEFS_SVH
`define PSC_WORD_BITS 6
`define PSC_PHASE_BITS 4
`define PSC_PHASE_LSB 2
`define PSC_SYS_PERIOD_NS 4
`define PSC_SCK_MIN_NS 100
`define PSC_SCK_HALF_CYC ((`PSC_SCK_MIN_NS + 2 * `PSC_SYS_PERIOD_NS - 1) / (2 * `PSC_SYS_PERIOD_NS))
`define PSC_LES_MIN_NS 630
`define PSC_LES_CYC ((`PSC_LES_MIN_NS + `PSC_SYS_PERIOD_NS - 1) / `PSC_SYS_PERIOD_NS)
`define PSC_LE_WIDTH_CYC 4
`define PSC_CNT_W 8
`define PSC_ADDR_CMD 2'h0
`define PSC_ADDR_STAT 2'h1
`define PSC_ADDR_ECHO 2'h2
`define PSC_CMD_GO_BIT 8
`define PSC_CMD_PAR_BIT 9
`endif

//--- include/psc_pkg.sv
// Purpose: Types shared by both ends of the phase shifter control link
// Assumes: Constants come from psc_defs.svh
// Notes: Host sequencer states live here
`include "psc_defs.svh"
package psc_pkg;
	typedef logic [`PSC_WORD_BITS-1:0] psc_word_t;
	typedef logic [`PSC_PHASE_BITS-1:0] psc_phase_t;
	typedef enum logic [2:0] {PSC_IDLE, PSC_LOW, PSC_HIGH, PSC_LATCH, PSC_GAP} psc_state_t;
endpackage : psc_pkg

//--- include/psc_link_if.sv
// Purpose: Pins between the host controller and the phase shifter driver
// Assumes: Host drives all control pins; device drives serial out
// Notes: Shared pins carry latch/clock/data or parallel bits by mode
`timescale 1ns/100ps
`default_nettype none
interface psc_link_if;
	logic mode_serial;
	logic latch_strobe;
	logic serial_clk;
	logic serial_data_in;
	logic phase_bit_180;
	logic phase_bit_90;
	logic phase_bit_45;
	logic serial_data_out;
	modport host (output mode_serial, latch_strobe, serial_clk, serial_data_in,
		phase_bit_180, phase_bit_90, phase_bit_45, input serial_data_out);
	modport dev (input mode_serial, latch_strobe, serial_clk, serial_data_in,
		phase_bit_180, phase_bit_90, phase_bit_45, output serial_data_out);
endinterface : psc_link_if
`default_nettype wire

//--- hdl/psc_host.sv
// Purpose: Host controller: shifts words to the phase shifter driver
// Assumes: Software uses the plain register port on sys_clk
// Notes: Serial clock made by divider from sys_clk
`timescale 1ns/100ps
`default_nettype none
`include "psc_defs.svh"
module psc_host (
	// System
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Register port
	input wire logic [1:0] addr,
	input wire logic [15:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [15:0] rd_data,
	// Link
	psc_link_if.host link
);
	import psc_pkg::*;

	psc_state_t state;
	psc_word_t word;
	psc_word_t echo;
	logic [2:0] bit_cnt;
	logic [`PSC_CNT_W-1:0] tmr;
	logic par_mode;
	logic pend;
	logic sclk;
	logic le;
	logic sdi;
	logic [2:0] sdo_sync;
	logic sdo_bit;

	wire cmd_wr = wr_en && addr == `PSC_ADDR_CMD;
	wire go = cmd_wr && wr_data[`PSC_CMD_GO_BIT];
	wire tmr_done = tmr == '0;
	// A queued word counts as busy so a second go cannot slip in before the sequencer starts
	wire busy = state != PSC_IDLE || pend;

	// Pins; parallel mode drives the word straight onto the shared pins
	assign link.mode_serial = !par_mode;
	assign link.latch_strobe = par_mode ? word[2] : le;
	assign link.serial_clk = par_mode ? word[1] : sclk;
	assign link.serial_data_in = par_mode ? 1'b0 : sdi;
	assign link.phase_bit_180 = word[5];
	assign link.phase_bit_90 = word[4];
	assign link.phase_bit_45 = par_mode ? word[3] : 1'b0;

	// Serial out resynchroniser, three flops
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			sdo_sync <= 3'h0;
		end else begin
			sdo_sync <= {sdo_sync[1:0], link.serial_data_out};
		end
	end

	// Serial out level taken only once the last two stages agree
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			sdo_bit <= 1'b0;
		end else if (sdo_sync[2] == sdo_sync[1]) begin
			sdo_bit <= sdo_sync[2];
		end
	end

	// Shift sequencer: MSB first, two dummy bits last, then latch pulse
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state <= PSC_IDLE;
			word <= 6'h00;
			echo <= 6'h00;
			bit_cnt <= 3'h0;
			tmr <= '0;
			par_mode <= 1'b0;
			pend <= 1'b0;
			sclk <= 1'b0;
			le <= 1'b0;
			sdi <= 1'b0;
		end else begin
			if (go && !busy) begin
				word <= {wr_data[`PSC_PHASE_BITS-1:0], 2'h0};
				par_mode <= wr_data[`PSC_CMD_PAR_BIT];
			end
			if (go && !busy && !wr_data[`PSC_CMD_PAR_BIT]) begin
				pend <= 1'b1;
			end else if (state == PSC_IDLE) begin
				pend <= 1'b0;
			end
			if (!tmr_done) begin
				tmr <= tmr - 1'b1;
			end
			unique case (state)
				PSC_IDLE: begin
					if (pend) begin
						state <= PSC_LOW;
						bit_cnt <= 3'h0;
						sdi <= word[5];
						tmr <= `PSC_CNT_W'(`PSC_SCK_HALF_CYC);
					end
				end
				PSC_LOW: begin
					if (tmr_done) begin
						sclk <= 1'b1;
						state <= PSC_HIGH;
						tmr <= `PSC_CNT_W'(`PSC_SCK_HALF_CYC);
					end
				end
				PSC_HIGH: begin
					if (tmr_done) begin
						sclk <= 1'b0;
						echo <= {echo[4:0], sdo_bit};
						tmr <= `PSC_CNT_W'(`PSC_SCK_HALF_CYC);
						if (bit_cnt == 3'h5) begin
							state <= PSC_LATCH;
						end else begin
							bit_cnt <= bit_cnt + 3'h1;
							sdi <= word[3'h4 - bit_cnt];
							state <= PSC_LOW;
						end
					end
				end
				PSC_LATCH: begin
					if (tmr_done) begin
						le <= !le;
						tmr <= `PSC_CNT_W'(le ? `PSC_LES_CYC : `PSC_LE_WIDTH_CYC);
						state <= le ? PSC_GAP : PSC_LATCH;
					end
				end
				PSC_GAP: begin
					if (tmr_done) begin
						state <= PSC_IDLE;
					end
				end
				// Unused codes of the three-bit state fall back to idle
				default: begin
					state <= PSC_IDLE;
				end
			endcase
		end
	end

	// Read data one cycle after the strobe
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rd_data <= 16'h0000;
		end else if (rd_en) begin
			unique case (addr)
				`PSC_ADDR_CMD: rd_data <= {6'h00, par_mode, 5'h00, word[5:2]};
				`PSC_ADDR_STAT: rd_data <= {15'h0000, busy};
				`PSC_ADDR_ECHO: rd_data <= {10'h000, echo};
				default: rd_data <= 16'h0000;
			endcase
		end else begin
			rd_data <= 16'h0000;
		end
	end
endmodule : psc_host
`default_nettype wire

//--- hdl/psc_dev.sv
// Purpose: Phase shifter driver: serial or parallel phase select
// Assumes: Serial clock comes from the host; no documented reset
// Notes: Serial phase output held in a flop clocked by the rising latch strobe
`timescale 1ns/100ps
`default_nettype none
`include "psc_defs.svh"
module psc_dev (
	// Link
	psc_link_if.dev link,
	// Phase state
	output logic [3:0] phase_state
);
	import psc_pkg::*;

	psc_word_t shreg;
	psc_phase_t held;

	wire serial = link.mode_serial;
	wire sclk_en = serial && !link.latch_strobe;
	// Parallel word from dedicated and shared pins, dummies dropped
	wire [3:0] par_phase = {link.phase_bit_180, link.phase_bit_90, link.phase_bit_45,
		link.latch_strobe};

	// Six-stage shift chain, masked while latch high
	always_ff @(posedge link.serial_clk) begin
		if (sclk_en) begin
			shreg <= {shreg[4:0], link.serial_data_in};
		end
	end

	// Latch on rising strobe; upper four bits weigh 180/90/45/22.5
	always_ff @(posedge link.latch_strobe) begin
		if (serial) begin
			held <= shreg[5:`PSC_PHASE_LSB];
		end
	end

	assign link.serial_data_out = shreg[5];
	assign phase_state = serial ? held : par_phase;
endmodule : psc_dev
`default_nettype wire

//--- tb/psc_props.sv
// Purpose: Link assertions
// Assumes: sys_clk samples the slow serial clock
// Notes: A shadow chain mirrors the driver
`timescale 1ns/100ps
`default_nettype none
module psc_props (
	// System
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Link
	input wire logic mode_serial,
	input wire logic latch_strobe,
	input wire logic serial_clk,
	input wire logic serial_data_in,
	input wire logic phase_bit_180,
	input wire logic phase_bit_90,
	input wire logic phase_bit_45,
	input wire logic serial_data_out,
	input wire logic [3:0] phase_state
);
	logic [5:0] shadow;
	logic [2:0] shifts;
	logic [7:0] gap;
	logic sck_q;
	logic le_q;
	logic seen;
	wire shift_now = serial_clk && !sck_q && mode_serial && !latch_strobe;
	wire le_rise = latch_strobe && !le_q && mode_serial;
	// Shadow chain, shift count and latch spacing
	always_ff @(posedge sys_clk) begin
		{sck_q, le_q} <= {serial_clk, latch_strobe};
		if (shift_now) shadow <= {shadow[4:0], serial_data_in};
		shifts <= sys_rst ? 3'h0 : shifts + {2'h0, shift_now && shifts != 3'h6};
		gap <= sys_rst ? 8'hFF : le_rise ? 8'h00 : gap + {7'h0, gap != 8'hFF};
		seen <= !sys_rst && (seen || le_rise);
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	latch_apply_a: assert property (le_rise && shifts == 3'h6 |-> ##[0:4] phase_state == shadow[5:2])
		else $error("latched phase wrong");
	hold_low_a: assert property (seen && mode_serial && !latch_strobe && $past(mode_serial && !latch_strobe)
		|-> $stable(phase_state)) else $error("phase moved with latch low");
	par_follow_a: assert property (!mode_serial |-> phase_state == {phase_bit_180, phase_bit_90,
		phase_bit_45, latch_strobe}) else $error("parallel phase wrong");
	echo_delay_a: assert property ($fell(serial_clk) && mode_serial && shifts == 3'h6
		|-> serial_data_out == shadow[5]) else $error("echo not six clocks late");
	le_mask_a: assert property (mode_serial && latch_strobe && $past(latch_strobe) && shifts == 3'h6
		|-> $stable(serial_data_out)) else $error("shift while latch high");
	par_idle_a: assert property (!mode_serial && $past(!mode_serial) && shifts == 3'h6
		|-> $stable(serial_data_out)) else $error("shift in parallel mode");
	sck_period_a: assert property ($fell(serial_clk) && mode_serial |-> $past(serial_clk, 12))
		else $error("serial clock too fast");
	le_space_a: assert property (le_rise |-> gap >= 8'h9D) else $error("latch pulses too close");
	cover property (le_rise && shifts == 3'h6);
	cover property ($fell(mode_serial));
	cover property (!mode_serial && phase_state == 4'hF);
endmodule : psc_props
`default_nettype wire

//--- tb/tb_phase_shifter_control_driver.sv
// Purpose: Host and driver on one link
// Assumes: Busy is bit 0 of register 1
// Notes: Seed 5; corner words first
`timescale 1ns/100ps
`default_nettype none
module tb_phase_shifter_control_driver;
	import psc_pkg::*;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [1:0] addr = 2'h0;
	logic [15:0] wr_data = 16'h0000;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [15:0] rd_data;
	psc_phase_t phase_state;
	psc_phase_t ph;
	psc_phase_t prev_ph;
	logic have_prev = 1'b0;
	logic par;
	int mismatches = 0;
	int samples_checked = 0;
	psc_link_if link ();
	psc_host u_psc_host (.sys_clk(sys_clk), .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .link(link.host));
	psc_dev u_psc_dev (.link(link.dev), .phase_state(phase_state));
	psc_props u_psc_props (.sys_clk(sys_clk), .sys_rst(sys_rst), .mode_serial(link.mode_serial),
		.latch_strobe(link.latch_strobe), .serial_clk(link.serial_clk),
		.serial_data_in(link.serial_data_in), .phase_bit_180(link.phase_bit_180),
		.phase_bit_90(link.phase_bit_90), .phase_bit_45(link.phase_bit_45),
		.serial_data_out(link.serial_data_out), .phase_state(phase_state));
	initial forever #2 sys_clk = ~sys_clk;
	// Compare and count
	task automatic check(input string what, input logic [5:0] exp, input logic [5:0] got);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// One strobe cycle; read data settled on return
	task automatic bus(input logic [1:0] a, input logic [15:0] d, input logic wr);
		@(posedge sys_clk);
		addr <= a;
		wr_data <= d;
		wr_en <= wr;
		rd_en <= !wr;
		@(posedge sys_clk);
		wr_en <= 1'b0;
		rd_en <= 1'b0;
		#1;
	endtask : bus
	// Issue a word and poll busy
	task automatic send(input psc_phase_t p, input logic pm);
		int n;
		n = 0;
		bus(2'h0, {6'h00, pm, 1'b1, 4'h0, p}, 1'b1);
		bus(2'h1, 16'h0000, 1'b0);
		while (rd_data[0] !== 1'b0 && n < 1000) begin
			bus(2'h1, 16'h0000, 1'b0);
			n++;
		end
		check("busy_wait", 4'h0, {3'h0, n == 1000});
		if (n == 1000) complete_run();
	endtask : send
	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : complete_run
	initial begin
		void'($urandom(5));
		repeat (12) @(posedge sys_clk);
		sys_rst <= 1'b0;
		for (int i = 0; i < 16; i++) begin
			ph = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : 4'($urandom);
			par = (i > 2) && 1'($urandom);
			send(ph, par);
			check("phase_state", ph, phase_state);
			if (!par) check("serial_data_out", {5'h00, ph[3]}, {5'h00, link.serial_data_out});
			bus(2'h0, 16'h0000, 1'b0);
			check("cmd_readback", {1'b0, par, ph}, {1'b0, rd_data[9], rd_data[3:0]});
			if (!par && have_prev) begin
				bus(2'h2, 16'h0000, 1'b0);
				check("echo", {prev_ph[2:0], 2'h0, ph[3]}, rd_data[5:0]);
			end
			if (!par) begin
				prev_ph = ph;
				have_prev = 1'b1;
			end
			$display("test %0d mode %0d phase %h done", i, par, ph);
		end
		complete_run();
	end
endmodule : tb_phase_shifter_control_driver
`default_nettype wire
